/* hw/event_summary_consts.vh */
`ifndef EVENT_SUMMARY_CONSTS_VH
`define EVENT_SUMMARY_CONSTS_VH

// Byte addresses on the register bus
`define OFS_EVENT_SUMMARY_STATUS  8'h00
`define OFS_BUFFER_STATUS         8'h04
`define OFS_SYSTEM_STATE          8'h08
`define OFS_BUFFER_SETUP          8'h0C
`define OFS_CHANGE_SRC_ONE        8'h10
`define OFS_CHANGE_SRC_TWO        8'h14
`define OFS_CHANGE_SETUP          8'h18
`define OFS_ORIENTATION_DETECTOR_STATE          8'h1C
`define OFS_IRQ_STATUS            8'h20
`define OFS_IRQ_MASK              8'h24

// Summary bit positions
`define BIT_BUFFER_SUMMARY        5
`define BIT_OUTSIDE_SUMMARY       4
`define BIT_WITHIN_SUMMARY        3
`define BIT_ORIENTATION_DETECTOR_SUMMARY        2

// Detail bit positions
`define BIT_BUF_WATERMARK         0
`define BIT_BUF_OVERFLOW          1
`define BIT_BUF_FULL              2
`define BIT_GATE_ERROR            0
`define BIT_OT_ACTIVE             0
`define BIT_WT_ACTIVE             0
`define BIT_OT_LATCH_EN           0
`define BIT_WT_LATCH_EN           1
`define BIT_NEW_ORIENTATION_INDICATION            0

// Buffer setup fields
`define BUF_MODE_LSB              0
`define BUF_MODE_MSB              1
`define BIT_ROUTE_PIN_A           2
`define BIT_ROUTE_PIN_B           3
`define BUF_MODE_DISABLED         2'b00
`define BUF_MODE_TRIGGERED        2'b11

// Reset values
`define RST_BYTE                  8'h00
`define RST_WORD                  32'h0000_0000

`endif

/* hw/threshold_flag.v */
`timescale 1ns/1ps
module threshold_flag (
  input  wire clk_i,
  input  wire rst_i,
  input  wire cond_i,
  input  wire latch_en_i,
  input  wire src_read_i,
  output reg  flag_o
);

  // Latched: condition wins over the clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (latch_en_i) begin
      flag_o <= cond_i | (flag_o & ~src_read_i);
    end else begin
      flag_o <= cond_i;
    end
  end

endmodule // threshold_flag

/* hw/sticky_irq.v */
`timescale 1ns/1ps
`include "event_summary_consts.vh"
module sticky_irq (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] event_i,
  input  wire [7:0] mask_i,
  input  wire       clear_i,
  output wire [7:0] sticky_o,
  output reg        irq_o
);

  reg [7:0] sticky_r;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      // Set wins over the clearing read
      always @(posedge clk_i) begin
        if (rst_i) begin
          sticky_r[i] <= 1'b0;
        end else begin
          sticky_r[i] <= event_i[i] | (sticky_r[i] & ~clear_i);
        end
      end
    end
  endgenerate

  assign sticky_o = sticky_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sticky_r & mask_i);
    end
  end

endmodule // sticky_irq

/* hw/event_status_flag_aggregator.v */
`timescale 1ns/1ps
`include "event_summary_consts.vh"
module event_status_flag_aggregator (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        buf_watermark_i,
  input  wire        buf_overflow_i,
  input  wire        buf_full_i,
  input  wire        buf_gate_error_i,
  input  wire        ot_condition_i,
  input  wire        wt_condition_i,
  input  wire        orientation_detector_change_i,
  output reg         interrupt_pin_a_o,
  output reg         interrupt_pin_b_o,
  output wire        irq_o
);

  reg  [7:0]  status_r;
  reg  [7:0]  status_nxt;
  reg  [7:0]  buffer_status_r;
  reg  [7:0]  system_state_r;
  reg  [7:0]  buffer_setup_r;
  reg  [7:0]  change_setup_r;
  reg  [7:0]  irq_mask_r;
  reg         new_orientation_indication_r;
  reg  [31:0] rd_data;
  reg         buf_summary;

  wire        bus_req;
  wire        rd_pulse;
  wire        wr_pulse;
  wire        rd_src_one;
  wire        rd_src_two;
  wire        rd_orientation_detector;
  wire        rd_irq;
  wire        lane0_wr;
  wire        ot_active;
  wire        wt_active;
  wire [7:0]  sticky;
  wire [1:0]  buf_mode;
  wire        triggered;

  // Bus access decode; an access is taken on the edge that raises ack
  assign bus_req    = cyc_i & stb_i & ~ack_o;
  assign rd_pulse   = bus_req & ~we_i;
  assign wr_pulse   = bus_req & we_i;
  assign lane0_wr   = wr_pulse & sel_i[0];
  assign rd_src_one = rd_pulse & (adr_i == `OFS_CHANGE_SRC_ONE);
  assign rd_src_two = rd_pulse & (adr_i == `OFS_CHANGE_SRC_TWO);
  assign rd_orientation_detector  = rd_pulse & (adr_i == `OFS_ORIENTATION_DETECTOR_STATE);
  assign rd_irq     = rd_pulse & (adr_i == `OFS_IRQ_STATUS);

  assign buf_mode  = buffer_setup_r[`BUF_MODE_MSB:`BUF_MODE_LSB];
  assign triggered = (buf_mode == `BUF_MODE_TRIGGERED);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // Writable setup registers; status and detail registers ignore writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      buffer_setup_r <= `RST_BYTE;
      change_setup_r <= `RST_BYTE;
      irq_mask_r     <= `RST_BYTE;
    end else if (lane0_wr) begin
      case (adr_i)
        `OFS_BUFFER_SETUP: begin
          buffer_setup_r <= dat_i[7:0];
        end
        `OFS_CHANGE_SETUP: begin
          change_setup_r <= dat_i[7:0];
        end
        `OFS_IRQ_MASK: begin
          irq_mask_r <= dat_i[7:0];
        end
        default: begin
          buffer_setup_r <= buffer_setup_r;
        end
      endcase
    end
  end

  // Buffer detail views
  always @(posedge clk_i) begin
    if (rst_i) begin
      buffer_status_r <= `RST_BYTE;
      system_state_r  <= `RST_BYTE;
    end else begin
      buffer_status_r <= `RST_BYTE;
      buffer_status_r[`BIT_BUF_WATERMARK] <= buf_watermark_i;
      buffer_status_r[`BIT_BUF_OVERFLOW]  <= buf_overflow_i;
      buffer_status_r[`BIT_BUF_FULL]      <= buf_full_i;
      system_state_r <= `RST_BYTE;
      system_state_r[`BIT_GATE_ERROR] <= buf_gate_error_i;
    end
  end

  // Buffer summary from the sources
  always @* begin
    buf_summary = 1'b0;
    if (buf_mode != `BUF_MODE_DISABLED) begin
      buf_summary = buf_overflow_i | buf_gate_error_i | buf_full_i;
      if (!triggered) begin
        buf_summary = buf_summary | buf_watermark_i;
      end
    end
  end

  threshold_flag u_outside (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cond_i     (ot_condition_i),
    .latch_en_i (change_setup_r[`BIT_OT_LATCH_EN]),
    .src_read_i (rd_src_one),
    .flag_o     (ot_active)
  );

  threshold_flag u_within (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cond_i     (wt_condition_i),
    .latch_en_i (change_setup_r[`BIT_WT_LATCH_EN]),
    .src_read_i (rd_src_two),
    .flag_o     (wt_active)
  );

  // New orientation flag; a fresh change wins over the clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      new_orientation_indication_r <= 1'b0;
    end else begin
      new_orientation_indication_r <= orientation_detector_change_i | (new_orientation_indication_r & ~rd_orientation_detector);
    end
  end

  // Summary register image
  always @* begin
    status_nxt = `RST_BYTE;
    status_nxt[`BIT_BUFFER_SUMMARY]  = buf_summary;
    status_nxt[`BIT_OUTSIDE_SUMMARY] = ot_active;
    status_nxt[`BIT_WITHIN_SUMMARY]  = wt_active;
    status_nxt[`BIT_ORIENTATION_DETECTOR_SUMMARY]  = new_orientation_indication_r;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= `RST_BYTE;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Buffer summary routed to the configured pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_pin_a_o <= 1'b0;
      interrupt_pin_b_o <= 1'b0;
    end else begin
      interrupt_pin_a_o <= buf_summary & buffer_setup_r[`BIT_ROUTE_PIN_A];
      interrupt_pin_b_o <= buf_summary & buffer_setup_r[`BIT_ROUTE_PIN_B];
    end
  end

  sticky_irq u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .event_i  (status_r),
    .mask_i   (irq_mask_r),
    .clear_i  (rd_irq),
    .sticky_o (sticky),
    .irq_o    (irq_o)
  );

  // Read multiplexer; unmapped addresses read zero
  always @* begin
    rd_data = `RST_WORD;
    case (adr_i)
      `OFS_EVENT_SUMMARY_STATUS: begin
        rd_data[7:0] = status_r;
      end
      `OFS_BUFFER_STATUS: begin
        rd_data[7:0] = buffer_status_r;
      end
      `OFS_SYSTEM_STATE: begin
        rd_data[7:0] = system_state_r;
      end
      `OFS_BUFFER_SETUP: begin
        rd_data[7:0] = buffer_setup_r;
      end
      `OFS_CHANGE_SRC_ONE: begin
        rd_data[`BIT_OT_ACTIVE] = ot_active;
      end
      `OFS_CHANGE_SRC_TWO: begin
        rd_data[`BIT_WT_ACTIVE] = wt_active;
      end
      `OFS_CHANGE_SETUP: begin
        rd_data[7:0] = change_setup_r;
      end
      `OFS_ORIENTATION_DETECTOR_STATE: begin
        rd_data[`BIT_NEW_ORIENTATION_INDICATION] = new_orientation_indication_r;
      end
      `OFS_IRQ_STATUS: begin
        rd_data[7:0] = sticky;
      end
      `OFS_IRQ_MASK: begin
        rd_data[7:0] = irq_mask_r;
      end
      default: begin
        rd_data = `RST_WORD;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `RST_WORD;
    end else if (rd_pulse) begin
      dat_o <= rd_data;
    end
  end

endmodule // event_status_flag_aggregator

/* sim/esfa_asserts.sv */
`timescale 1ns/1ps
module esfa_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        buf_watermark_i,
  input wire        buf_overflow_i,
  input wire        buf_full_i,
  input wire        buf_gate_error_i,
  input wire        ot_condition_i,
  input wire        wt_condition_i,
  input wire        orientation_detector_change_i,
  input wire        interrupt_pin_a_o,
  input wire        interrupt_pin_b_o
);
  reg  [7:0] rd_adr_r;
  wire       src_any = buf_watermark_i | buf_overflow_i | buf_full_i | buf_gate_error_i;
  wire       rd0 = ack_o & (rd_adr_r == 8'h00);
  // Address of the read answered in the ack cycle
  always @(posedge clk_i) begin
    rd_adr_r <= (cyc_i & stb_i & ~we_i & ~ack_o) ? adr_i : 8'hff;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (cyc_i & stb_i & ~ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
  a_status_pad_zero: assert property (rd0 |-> {dat_o[31:6], dat_o[1:0]} == 28'h000_0000)
    else $error("unused status bits set");
  a_buf_summary_cause: assert property (rd0 && dat_o[5] |-> $past(src_any, 2))
    else $error("buffer summary without source");
  a_outside_copy: assert property (rd0 && $past(ot_condition_i, 3) |-> dat_o[4])
    else $error("outside flag missing");
  a_within_copy: assert property (rd0 && $past(wt_condition_i, 3) |-> dat_o[3])
    else $error("within flag missing");
  a_orientation_detector_set: assert property (rd0 && $past(orientation_detector_change_i, 3) |-> dat_o[2])
    else $error("orientation flag missing");
  a_src_one_bit: assert property (ack_o && rd_adr_r == 8'h10 && $past(ot_condition_i, 2) |-> dat_o[0])
    else $error("source one bit missing");
  a_src_two_bit: assert property (ack_o && rd_adr_r == 8'h14 && $past(wt_condition_i, 2) |-> dat_o[0])
    else $error("source two bit missing");
  a_pin_a_cause: assert property (interrupt_pin_a_o |-> $past(src_any))
    else $error("pin a without buffer event");
  a_pin_b_cause: assert property (interrupt_pin_b_o |-> $past(src_any))
    else $error("pin b without buffer event");
endmodule // esfa_chk
bind event_status_flag_aggregator esfa_chk esfa_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
  .ack_o, .buf_watermark_i, .buf_overflow_i, .buf_full_i, .buf_gate_error_i, .ot_condition_i,
  .wt_condition_i, .orientation_detector_change_i, .interrupt_pin_a_o, .interrupt_pin_b_o);

/* sim/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        go_i,
  input  wire        wr_i,
  input  wire [7:0]  a_i,
  input  wire [31:0] d_i,
  input  wire        ack_i,
  input  wire [31:0] rd_i,
  output reg         cyc_o,
  output reg         we_o,
  output reg  [7:0]  adr_o,
  output reg  [31:0] dat_o,
  output reg  [31:0] q_o,
  output reg         done_o
);
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cyc_o <= 1'b0;
      we_o  <= 1'b0;
      adr_o <= 8'h00;
      dat_o <= 32'h0000_0000;
      q_o   <= 32'h0000_0000;
    end else if (cyc_o & ack_i) begin
      cyc_o  <= 1'b0;
      q_o    <= rd_i;
      done_o <= 1'b1;
    end else if (go_i & ~cyc_o & ~done_o) begin
      cyc_o <= 1'b1;
      we_o  <= wr_i;
      adr_o <= a_i;
      dat_o <= d_i;
    end else if (~cyc_o) begin
      // Released lines toggle so stale values never pass
      adr_o <= ~adr_o;
      dat_o <= ~dat_o;
    end
  end
endmodule // host_model

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  reg clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, wr = 1'b0;
  reg [7:0] a = 8'h00;
  reg [31:0] d = 32'h0000_0000, seed = 32'h0f3e_c41b;
  reg wm = 1'b0, ovf = 1'b0, full = 1'b0, gate = 1'b0, ot = 1'b0, wt = 1'b0, oc = 1'b0;
  wire cyc, we, ack, done, pa, pb, irq;
  wire [7:0] adr;
  wire [31:0] wdat, rdat, q;
  integer error_cnt = 0, checks_done = 0, i, bs, st_m, ot_m = 0, wt_m = 0, or_m = 0, sticky_m = 0;
  always #20 clk_i = ~clk_i;
  event_status_flag_aggregator event_status_flag_aggregator_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(cyc), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(4'hf), .dat_o(rdat), .ack_o(ack),
    .buf_watermark_i(wm), .buf_overflow_i(ovf), .buf_full_i(full), .buf_gate_error_i(gate),
    .ot_condition_i(ot), .wt_condition_i(wt), .orientation_detector_change_i(oc), .interrupt_pin_a_o(pa),
    .interrupt_pin_b_o(pb), .irq_o(irq));
  host_model host_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .wr_i(wr), .a_i(a), .d_i(d), .ack_i(ack),
    .rd_i(rdat), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat), .q_o(q), .done_o(done));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task end_sim;
    begin
      if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] ad, input [31:0] dd);
    integer k;
    begin
      go <= 1'b1;
      wr <= w;
      a  <= ad;
      d  <= dd;
      for (k = 0; k < 20 && done !== 1'b1; k = k + 1) @(posedge clk_i);
      go <= 1'b0;
      if (k == 20) begin
        error_cnt = error_cnt + 1;
        end_sim;
      end
      // Let an edge pass so go is not driven twice in one step
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] ad, input [31:0] exp);
    begin
      bus(1'b0, ad, 32'h0000_0000);
      cmp(q, exp);
    end
  endtask
  initial begin
    #(40 * 20000);
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h0C, 0);
    rd(8'h18, 0);
    rd(8'h24, 0);
    rd(8'h30, 0);
    for (i = 0; i < 60; i = i + 1) begin
      seed = xs(seed);
      bus(1'b1, 8'h0C, {28'h000_0000, seed[3:0]});
      bus(1'b1, 8'h18, {30'h0000_0000, seed[5:4]});
      bus(1'b1, 8'h24, {24'h00_0000, seed[15:8]});
      bus(1'b1, 8'h00, seed);
      // New mode seen with old sources for a while
      bs = (seed[1:0] != 0) && ((wm && seed[1:0] != 3) || ovf || full || gate);
      sticky_m = sticky_m | (bs * 32) | (ot_m * 16) | (wt_m * 8) | (or_m * 4);
      {oc, wt, ot, gate, full, ovf, wm} <= seed[22:16];
      ot_m = seed[20] | (seed[4] & ot_m);
      wt_m = seed[21] | (seed[5] & wt_m);
      or_m = or_m | seed[22];
      repeat (5) @(posedge clk_i);
      bs = (seed[1:0] != 0) && ((seed[16] && seed[1:0] != 3) || seed[19:17] != 0);
      st_m = bs * 32 + ot_m * 16 + wt_m * 8 + or_m * 4;
      sticky_m = sticky_m | st_m;
      cmp(pa, bs & seed[2]);
      cmp(pb, bs & seed[3]);
      cmp(irq, |(sticky_m & seed[15:8]));
      rd(8'h00, st_m);
      rd(8'h04, seed[18:16]);
      rd(8'h08, seed[19]);
      rd(8'h10, ot_m);
      rd(8'h14, wt_m);
      bus(1'b0, 8'h1C, 32'h0000_0000);
      ot_m = seed[20];
      wt_m = seed[21];
      or_m = seed[22];
      repeat (3) @(posedge clk_i);
      st_m = bs * 32 + ot_m * 16 + wt_m * 8 + or_m * 4;
      rd(8'h00, st_m);
      rd(8'h20, sticky_m);
      sticky_m = st_m;
    end
    end_sim;
  end
endmodule // testbench
